//--- bench/lui_clk_src.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// line-side clock sources
// ------------------------------------------------------------
module lui_clk_src #(
  parameter int REF_HALF_NS = 244,
  parameter int TX_HALF_NS  = 250
) (
  input  wire logic ref_run,
  input  wire logic tx_run,
  output logic      master_ref_clock,
  output logic      tx_line_clock
);
  // a stopped clock rests low, as a dead oscillator would
  initial master_ref_clock = 1'b0;
  initial tx_line_clock = 1'b0;
  always #(REF_HALF_NS) master_ref_clock = ref_run ? ~master_ref_clock : 1'b0;
  always #(TX_HALF_NS) tx_line_clock = tx_run ? ~tx_line_clock : 1'b0;
endmodule : lui_clk_src

//--- bench/lui_irq_checker.sv
`timescale 1ns/100ps
module lui_irq_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [4:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       signal_loss_status,
  input wire logic       alarm_ind_status,
  input wire logic       driver_fault_status,
  input wire logic       pattern_sync_status,
  input wire logic       loop_activate_code_status,
  input wire logic       loop_deactivate_code_status,
  input wire logic       remote_loop_active,
  input wire logic       pattern_tx_active,
  input wire logic [7:0] pulse_events,
  input wire logic       irq_out,
  input wire logic       irq_oe,
  input wire logic       line_driver_oe,
  input wire logic       pattern_clock_use_ref,
  input wire logic       rx_clock_from_ref,
  input wire logic       tx_clock_lost_status
);
  // ------------------------------------------------------------
  // shadow settings
  // ------------------------------------------------------------
  logic [7:0] cfg_q, maint_q, mask_q, es_q, live_q;
  // bit 3 left out: that flag comes from the clock monitor, not a port
  wire  [7:0] live   = {1'b0, loop_activate_code_status, loop_deactivate_code_status,
    pattern_sync_status, 1'b0, driver_fault_status, alarm_ind_status, signal_loss_status};
  wire  [7:0] trig   = (live & ~live_q) | ((live ^ live_q) & es_q);
  wire        act    = (cfg_q[1:0] == 2'h2) ? (irq_oe & irq_out) : (irq_oe & ~irq_out);
  wire        wr_cfg = reg_wr && reg_addr == lui_pkg::ADDR_GLOBAL_CONFIG;
  // mirror host writes so mode-dependent checks know the setting
  always_ff @(posedge clk) begin
    if (rst) begin
      {cfg_q, maint_q, es_q, live_q} <= 32'h0;
      mask_q <= 8'hFF;
    end else begin
      live_q <= live;
      if (wr_cfg) cfg_q <= reg_wdata;
      if (reg_wr && reg_addr == lui_pkg::ADDR_MAINT_PATTERN) maint_q <= reg_wdata;
      if (reg_wr && reg_addr == lui_pkg::ADDR_IRQ_MASK_HIGH) mask_q <= reg_wdata;
      if (reg_wr && reg_addr == lui_pkg::ADDR_IRQ_EDGE_SEL) es_q <= reg_wdata;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_hi_read;
    reg_rd && reg_addr == lui_pkg::ADDR_IRQ_STAT_HIGH;
  endsequence
  sequence s_lo_read;
    reg_rd && reg_addr == lui_pkg::ADDR_IRQ_STAT_LOW;
  endsequence
  chk_od_never_high: assert property (cfg_q[1:0] == 2'h0 && $stable(cfg_q) |-> !irq_out)
    else $error("open-drain pin driven high");
  chk_pp_drives: assert property (cfg_q[1:0] != 2'h0 && $stable(cfg_q) |-> irq_oe)
    else $error("push-pull pin not driven");
  chk_irq_raise: assert property ((pulse_events & ~mask_q) != 8'h00 && !wr_cfg |=> act)
    else $error("unmasked event did not activate pin");
  chk_hi_capture: assert property (pulse_events != 8'h00 ##1 s_hi_read
    |=> (reg_rdata & $past(pulse_events, 2)) == $past(pulse_events, 2)) else $error("flag lost");
  chk_hi_clear: assert property (s_hi_read ##0 pulse_events == 8'h00 ##1
    pulse_events == 8'h00 ##1 s_hi_read |=> reg_rdata == 8'h00) else $error("flag not cleared");
  chk_lo_edge: assert property (trig != 8'h00 ##2 s_lo_read
    |=> (reg_rdata & $past(trig, 3)) == $past(trig, 3)) else $error("status edge not flagged");
  chk_drv_off: assert property (tx_clock_lost_status && !$past(remote_loop_active)
    && !$past(pattern_tx_active) |-> !line_driver_oe) else $error("driver on after clock loss");
  chk_rx_ref: assert property (1'b1 |=> rx_clock_from_ref ==
    $past(signal_loss_status & maint_q[1])) else $error("rx clock source wrong");
  chk_pat_ref: assert property (1'b1 |=> pattern_clock_use_ref ==
    $past(|(maint_q & 8'h13))) else $error("pattern clock source wrong");
endmodule : lui_irq_checker

bind lui_irq_clk_sup lui_irq_checker lui_irq_checker_inst (.clk, .rst, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .signal_loss_status, .alarm_ind_status,
  .driver_fault_status, .pattern_sync_status, .loop_activate_code_status,
  .loop_deactivate_code_status, .remote_loop_active, .pattern_tx_active, .pulse_events,
  .irq_out, .irq_oe, .line_driver_oe, .pattern_clock_use_ref, .rx_clock_from_ref,
  .tx_clock_lost_status);

//--- bench/tb_lui_irq_clk_sup.sv
`timescale 1ns/100ps
module tb_lui_irq_clk_sup;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  reg_addr = 5'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  lv = 8'h00;
  logic [7:0]  pulse_events = 8'h00;
  logic        remote_loop_active = 1'b0;
  logic        ref_run = 1'b1;
  logic        tx_run = 1'b1;
  logic        tx_din = 1'b0;
  logic        tx_esel = 1'b0;
  logic        pat_act = 1'b0;
  logic        smp, t1, bt;
  logic [7:0]  reg_rdata, d, m;
  logic        master_ref_clock, tx_line_clock, irq_out, irq_oe, drv_oe, use_ref, rx_ref, lost;
  logic [12:0] rst_tab [8] = '{13'h0200, 13'h0D00, 13'h147F, 13'h15FF, 13'h1600, 13'h1900,
                               13'h1A00, 13'h1F00};
  logic [7:0]  mt [5] = '{8'h01, 8'h02, 8'h10, 8'h00, 8'h12};
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #(lui_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  lui_clk_src lui_clk_src_inst (.ref_run(ref_run), .tx_run(tx_run),
    .master_ref_clock(master_ref_clock), .tx_line_clock(tx_line_clock));
  lui_irq_clk_sup lui_irq_clk_sup_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .master_ref_clock(master_ref_clock), .tx_line_clock(tx_line_clock), .tx_data_in(tx_din),
    .tx_sample_edge_sel(tx_esel), .signal_loss_status(lv[0]), .alarm_ind_status(lv[1]),
    .driver_fault_status(lv[2]), .pattern_sync_status(lv[4]),
    .loop_deactivate_code_status(lv[5]), .loop_activate_code_status(lv[6]),
    .remote_loop_active(remote_loop_active), .pattern_tx_active(pat_act),
    .pulse_events(pulse_events), .irq_out(irq_out), .irq_oe(irq_oe), .line_driver_oe(drv_oe),
    .pattern_clock_use_ref(use_ref), .rx_clock_from_ref(rx_ref), .tx_data_sampled(smp),
    .tx_clock_lost_status(lost), .line_rate_t1(t1));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle strobes; the idle cycle after each keeps strobes apart
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask : rd
  // expected {oe, out} of the interrupt pin for a mode and activity
  function automatic logic [7:0] pin_exp(input logic [1:0] c, input logic act);
    if (c == 2'h0) return {6'h00, act, 1'b0};
    if (c == 2'h2) return {7'h01, act};
    return {7'h01, ~act};
  endfunction : pin_exp
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(97000));
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk({irq_oe, irq_out}, 8'h00);
    wr(5'h1A, 8'hFF);
    foreach (rst_tab[i]) begin
      rd(rst_tab[i][12:8], d);
      chk(d, rst_tab[i][7:0]);
    end
    $display("reset test done");
    // every pin mode against every pulse event, random masks except all-unmasked in mode 1
    for (int c = 0; c < 4; c++) begin
      m = (c == 1) ? 8'h00 : 8'($urandom);
      wr(5'h02, 8'(c));
      wr(5'h15, m);
      for (int k = 0; k < 8; k++) begin
        @(negedge clk) pulse_events = 8'h01 << k;
        @(negedge clk) pulse_events = 8'h00;
        chk({irq_oe, irq_out}, pin_exp(2'(c), ~m[k]));
        rd(5'h1A, d);
        chk(d, 8'h01 << k);
        chk({irq_oe, irq_out}, pin_exp(2'(c), 1'b0));
        rd(5'h1A, d);
        chk(d, 8'h00);
      end
    end
    $display("event test done");
    // live status edges under a random edge selection
    m = 8'($urandom) & 8'h77;
    wr(5'h16, m);
    wr(5'h14, 8'h00);
    for (int k = 0; k < 7; k++) begin
      if (k == 3) continue;
      lv[k] = 1'b1;
      @(negedge clk);
      rd(5'h19, d);
      chk(d, 8'h01 << k);
      lv[k] = 1'b0;
      @(negedge clk);
      rd(5'h19, d);
      chk(d, m[k] ? 8'h01 << k : 8'h00);
    end
    $display("edge test done");
    // tx clock loss, timed in reference cycles
    tx_run = 1'b0;
    repeat (66) @(posedge master_ref_clock);
    @(negedge clk) chk(lost, 8'h00);
    repeat (9) @(posedge master_ref_clock);
    repeat (4) @(negedge clk);
    chk(lost, 8'h01);
    chk(drv_oe, 8'h00);
    rd(5'h19, d);
    chk(d, 8'h08);
    remote_loop_active = 1'b1;
    repeat (3) @(negedge clk);
    chk(drv_oe, 8'h01);
    // patterns on the tx clock keep the driver off, on the reference they do not
    remote_loop_active = 1'b0;
    pat_act = 1'b1;
    repeat (3) @(negedge clk);
    chk(drv_oe, 8'h00);
    wr(5'h0D, 8'h10);
    repeat (2) @(negedge clk);
    chk(drv_oe, 8'h01);
    pat_act = 1'b0;
    tx_run = 1'b1;
    repeat (40) @(negedge clk);
    chk(lost, 8'h00);
    rd(5'h19, d);
    chk(d, 8'h00);
    $display("clock loss test done");
    // pattern clock and receive clock selection
    lv[0] = 1'b1;
    foreach (mt[i]) begin
      wr(5'h0D, mt[i]);
      @(negedge clk);
      chk(use_ref, |(mt[i] & 8'h13));
      chk(rx_ref, mt[i][1]);
    end
    lv[0] = 1'b0;
    // a dead reference must park the line driver
    ref_run = 1'b0;
    repeat (lui_pkg::REF_STOP_CLKS + 10) @(negedge clk);
    chk(drv_oe, 8'h00);
    ref_run = 1'b1;
    $display("clock select test done");
    // tx data taken on the selected edge only; data flips before the other edge
    for (int i = 0; i < 8; i++) begin
      if (i[0]) @(posedge tx_line_clock);
      else @(negedge tx_line_clock);
      @(negedge clk);
      tx_esel = i[0];
      bt = 1'($urandom);
      tx_din = bt;
      if (i[0]) @(negedge tx_line_clock);
      else @(posedge tx_line_clock);
      repeat (4) @(negedge clk);
      chk(smp, bt);
      tx_din = ~bt;
      if (i[0]) @(posedge tx_line_clock);
      else @(negedge tx_line_clock);
      repeat (4) @(negedge clk);
      chk(smp, bt);
    end
    wr(5'h02, 8'h04);
    @(negedge clk);
    chk(t1, 8'h01);
    $display("tx sample test done");
    close_out();
  end

  // hang guard, well beyond the longest wait above
  initial begin
    #(lui_pkg::CLK_PERIOD_NS * 20000);
    n_mismatch++;
    close_out();
  end
endmodule : tb_lui_irq_clk_sup

//--- core/lui_irq_clk_sup.sv
`timescale 1ns/100ps
// Behaviour
// - interrupt pin config 00 gives open-drain active-low output
// - config 01 gives push-pull active low, 10 push-pull active high
// - every event has its own flag bit in the two flag registers
// - every event has its own mask bit in the two mask registers
// - events with live status set their flag per an edge select bit
// - edge select 0 flags rising change only, 1 flags any change
// - reading a flag register makes the interrupt output inactive unless the other holds unmasked flags or an unmasked event sets a flag in the read cycle
// - flag bits clear when the register holding them is read
// - mask bit 0 lets the event interrupt, 1 suppresses it
// - fifteen event sources are supported
// - seven events have live status and edge select, others flag and mask
// - tx clock lost set after more than 70 reference cycles without edges
// - tx clock loss disables driver unless remote loop or ref-clock patterns
// - tx clock lost status clears once tx clock edges return
// - tx clock loss is timed from the master reference clock
// - pattern clock select picks tx clock or reference for test patterns
// - auto all-ones and alarm indication always use the reference clock
// - a stopped reference clock puts the line driver in high impedance
// - signal loss with alarm indication enabled takes rx clock from reference
// - tx data is sampled on the tx clock edge chosen by a select bit
module lui_irq_clk_sup #(
  parameter int LOSS_CYCLES = lui_pkg::TX_CLK_LOSS_REF_CYCLES,
  parameter int STOP_CLKS   = lui_pkg::REF_STOP_CLKS
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [4:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       master_ref_clock,
  input  wire logic       tx_line_clock,
  input  wire logic       tx_data_in,
  input  wire logic       tx_sample_edge_sel,
  input  wire logic       signal_loss_status,
  input  wire logic       alarm_ind_status,
  input  wire logic       driver_fault_status,
  input  wire logic       pattern_sync_status,
  input  wire logic       loop_activate_code_status,
  input  wire logic       loop_deactivate_code_status,
  input  wire logic       remote_loop_active,
  input  wire logic       pattern_tx_active,
  input  wire logic [7:0] pulse_events,
  output logic            irq_out,
  output logic            irq_oe,
  output logic            line_driver_oe,
  output logic            pattern_clock_use_ref,
  output logic            rx_clock_from_ref,
  output logic            tx_data_sampled,
  output logic            tx_clock_lost_status,
  output logic            line_rate_t1
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ref_sync_reg;
  logic [2:0] tx_line_clock_sync_reg;
  logic [1:0] tdata_sync_reg;

  // stage 0 is read only by stage 1; stage 2 is the edge history
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_sync_reg   <= 3'h0;
      tx_line_clock_sync_reg  <= 3'h0;
      tdata_sync_reg <= 2'h0;
    end else begin
      ref_sync_reg   <= {ref_sync_reg[1:0], master_ref_clock};
      tx_line_clock_sync_reg  <= {tx_line_clock_sync_reg[1:0], tx_line_clock};
      tdata_sync_reg <= {tdata_sync_reg[0], tx_data_in};
    end
  end

  wire ref_rise  = ref_sync_reg[1] & ~ref_sync_reg[2];
  wire tx_line_clock_rise = tx_line_clock_sync_reg[1] & ~tx_line_clock_sync_reg[2];
  wire tx_line_clock_fall = ~tx_line_clock_sync_reg[1] & tx_line_clock_sync_reg[2];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] global_config_reg;
  logic [7:0] maint_pattern_reg;
  logic [7:0] mask_low_reg;
  logic [7:0] mask_high_reg;
  logic [7:0] edge_sel_reg;

  wire wr_gcf   = reg_wr & (reg_addr == lui_pkg::ADDR_GLOBAL_CONFIG);
  wire wr_maint = reg_wr & (reg_addr == lui_pkg::ADDR_MAINT_PATTERN);
  wire wr_mlow  = reg_wr & (reg_addr == lui_pkg::ADDR_IRQ_MASK_LOW);
  wire wr_mhigh = reg_wr & (reg_addr == lui_pkg::ADDR_IRQ_MASK_HIGH);
  wire wr_edge  = reg_wr & (reg_addr == lui_pkg::ADDR_IRQ_EDGE_SEL);

  // reserved bits are dropped on write so they always read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      global_config_reg <= lui_pkg::RST_GLOBAL_CONFIG;
      maint_pattern_reg <= lui_pkg::RST_MAINT_PATTERN;
      mask_low_reg      <= lui_pkg::RST_MASK_LOW;
      mask_high_reg     <= lui_pkg::RST_MASK_HIGH;
      edge_sel_reg      <= lui_pkg::RST_EDGE_SEL;
    end else begin
      if (wr_gcf) global_config_reg <= reg_wdata & lui_pkg::GCF_RW_BITS;
      if (wr_maint) maint_pattern_reg <= reg_wdata & lui_pkg::LOW_RW_BITS;
      if (wr_mlow) mask_low_reg <= reg_wdata & lui_pkg::LOW_RW_BITS;
      if (wr_mhigh) mask_high_reg <= reg_wdata;
      if (wr_edge) edge_sel_reg <= reg_wdata & lui_pkg::LOW_RW_BITS;
    end
  end

  wire [1:0] int_pin_cfg = global_config_reg[lui_pkg::GCF_INT_PIN_LSB +: 2];
  wire auto_all_ones_en    = maint_pattern_reg[lui_pkg::MP_AUTO_ALL_ONES];
  wire alarm_indication_en = maint_pattern_reg[lui_pkg::MP_ALARM_IND_EN];
  wire pattern_clock_sel   = maint_pattern_reg[lui_pkg::MP_PATTERN_CLK];

  // ----------------------------------------------------------------
  // tx clock loss, timed in reference clock cycles
  // ----------------------------------------------------------------
  logic [7:0] loss_count_reg;
  logic [7:0] loss_count_next;
  logic       tx_lost_reg;
  logic       tx_lost_next;

  // counter saturates just past the limit so it never wraps back to "ok"
  always_comb begin
    loss_count_next = loss_count_reg;
    tx_lost_next    = tx_lost_reg;
    if (tx_line_clock_rise) begin
      loss_count_next = 8'h00;
      tx_lost_next    = 1'b0;
    end else if (ref_rise) begin
      if (loss_count_reg <= 8'(LOSS_CYCLES)) begin
        loss_count_next = loss_count_reg + 8'h01;
      end
      if (loss_count_reg >= 8'(LOSS_CYCLES)) begin
        tx_lost_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loss_count_reg <= 8'h00;
      tx_lost_reg    <= 1'b0;
    end else begin
      loss_count_reg <= loss_count_next;
      tx_lost_reg    <= tx_lost_next;
    end
  end

  // ----------------------------------------------------------------
  // reference clock stop detection, counted in core cycles
  // ----------------------------------------------------------------
  logic [15:0] stop_count_reg;
  logic        ref_stopped_reg;

  wire stop_limit = (stop_count_reg >= 16'(STOP_CLKS));

  always_ff @(posedge clk) begin
    if (rst) begin
      stop_count_reg  <= 16'h0000;
      ref_stopped_reg <= 1'b0;
    end else begin
      if (ref_rise) stop_count_reg <= 16'h0000;
      else if (!stop_limit) stop_count_reg <= stop_count_reg + 16'h0001;
      ref_stopped_reg <= stop_limit & ~ref_rise;
    end
  end

  // ----------------------------------------------------------------
  // event capture
  // ----------------------------------------------------------------
  logic [7:0] live_low;
  logic [7:0] live_prev_reg;
  logic [7:0] flag_low_reg;
  logic [7:0] flag_high_reg;

  // six live status inputs plus the internal tx clock loss
  always_comb begin
    live_low = 8'h00;
    live_low[lui_pkg::LO_SIGNAL_LOSS]   = signal_loss_status;
    live_low[lui_pkg::LO_ALARM_IND]     = alarm_ind_status;
    live_low[lui_pkg::LO_DRIVER_FAULT]  = driver_fault_status;
    live_low[lui_pkg::LO_TX_CLOCK_LOST] = tx_lost_reg;
    live_low[lui_pkg::LO_PATTERN_SYNC]  = pattern_sync_status;
    live_low[lui_pkg::LO_LOOP_DEACT]    = loop_deactivate_code_status;
    live_low[lui_pkg::LO_LOOP_ACT]      = loop_activate_code_status;
  end

  // edge select 0 flags a rise only, 1 flags any change
  wire [7:0] live_rise = live_low & ~live_prev_reg;
  wire [7:0] live_chg  = live_low ^ live_prev_reg;
  wire [7:0] set_low   = (edge_sel_reg & live_chg) | (~edge_sel_reg & live_rise);

  wire rd_flag_low  = reg_rd & (reg_addr == lui_pkg::ADDR_IRQ_STAT_LOW);
  wire rd_flag_high = reg_rd & (reg_addr == lui_pkg::ADDR_IRQ_STAT_HIGH);

  // an event in the read cycle survives: set wins over the read clear
  wire [7:0] flag_low_next  = (rd_flag_low ? 8'h00 : flag_low_reg) | set_low;
  wire [7:0] flag_high_next = (rd_flag_high ? 8'h00 : flag_high_reg) | pulse_events;

  always_ff @(posedge clk) begin
    if (rst) begin
      live_prev_reg <= 8'h00;
      flag_low_reg  <= 8'h00;
      flag_high_reg <= 8'h00;
    end else begin
      live_prev_reg <= live_low;
      flag_low_reg  <= flag_low_next & lui_pkg::LOW_RW_BITS;
      flag_high_reg <= flag_high_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  // uses next flag values so the read clear drops the pin on the next edge
  wire irq_pending = |((flag_low_next & ~mask_low_reg) | (flag_high_next & ~mask_high_reg));

  // open drain only ever pulls low; the pull-up gives the idle level
  wire irq_out_next = (int_pin_cfg == lui_pkg::INT_PIN_PP_HIGH) ? irq_pending :
                      ((int_pin_cfg == lui_pkg::INT_PIN_OPEN_DRAIN) ? 1'b0 : ~irq_pending);
  wire irq_oe_next  = (int_pin_cfg == lui_pkg::INT_PIN_OPEN_DRAIN) ? irq_pending : 1'b1;

  // ----------------------------------------------------------------
  // clock selection and line driver control
  // ----------------------------------------------------------------
  wire use_ref_next = auto_all_ones_en | alarm_indication_en | pattern_clock_sel;
  wire ref_patterns = pattern_tx_active & use_ref_next;
  wire lost_blocks  = tx_lost_reg & ~(remote_loop_active | ref_patterns);
  wire driver_next  = ~ref_stopped_reg & ~lost_blocks;
  wire rx_ref_next  = signal_loss_status & alarm_indication_en;
  wire sample_now   = tx_sample_edge_sel ? tx_line_clock_fall : tx_line_clock_rise;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  // unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      lui_pkg::ADDR_GLOBAL_CONFIG:  rd_mux = global_config_reg;
      lui_pkg::ADDR_MAINT_PATTERN:  rd_mux = maint_pattern_reg;
      lui_pkg::ADDR_IRQ_MASK_LOW:   rd_mux = mask_low_reg;
      lui_pkg::ADDR_IRQ_MASK_HIGH:  rd_mux = mask_high_reg;
      lui_pkg::ADDR_IRQ_EDGE_SEL:   rd_mux = edge_sel_reg;
      lui_pkg::ADDR_LINE_STAT_LOW:  rd_mux = live_low;
      lui_pkg::ADDR_LINE_STAT_HIGH: rd_mux = 8'(remote_loop_active) << lui_pkg::HI_REMOTE_LOOP;
      lui_pkg::ADDR_IRQ_STAT_LOW:   rd_mux = flag_low_reg;
      lui_pkg::ADDR_IRQ_STAT_HIGH:  rd_mux = flag_high_reg;
      default:                      rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  // driver held off in reset, matching the idle state of the line
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata             <= 8'h00;
      irq_out               <= 1'b0;
      irq_oe                <= 1'b0;
      line_driver_oe        <= 1'b0;
      pattern_clock_use_ref <= 1'b0;
      rx_clock_from_ref     <= 1'b0;
      tx_data_sampled       <= 1'b0;
      tx_clock_lost_status  <= 1'b0;
      line_rate_t1          <= 1'b0;
    end else begin
      if (reg_rd) reg_rdata <= rd_mux;
      irq_out               <= irq_out_next;
      irq_oe                <= irq_oe_next;
      line_driver_oe        <= driver_next;
      pattern_clock_use_ref <= use_ref_next;
      rx_clock_from_ref     <= rx_ref_next;
      if (sample_now) tx_data_sampled <= tdata_sync_reg[1];
      tx_clock_lost_status  <= tx_lost_reg;
      line_rate_t1          <= global_config_reg[lui_pkg::GCF_T1E1_BIT];
    end
  end

endmodule : lui_irq_clk_sup

//--- pkg/lui_pkg.sv
package lui_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_GLOBAL_CONFIG   = 5'h02;
  localparam logic [4:0] ADDR_MAINT_PATTERN   = 5'h0D;
  localparam logic [4:0] ADDR_IRQ_MASK_LOW    = 5'h14;
  localparam logic [4:0] ADDR_IRQ_MASK_HIGH   = 5'h15;
  localparam logic [4:0] ADDR_IRQ_EDGE_SEL    = 5'h16;
  localparam logic [4:0] ADDR_LINE_STAT_LOW   = 5'h17;
  localparam logic [4:0] ADDR_LINE_STAT_HIGH  = 5'h18;
  localparam logic [4:0] ADDR_IRQ_STAT_LOW    = 5'h19;
  localparam logic [4:0] ADDR_IRQ_STAT_HIGH   = 5'h1A;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // global_config
  localparam int GCF_INT_PIN_LSB   = 0;
  localparam int GCF_T1E1_BIT      = 2;
  // maintenance_pattern_control
  localparam int MP_AUTO_ALL_ONES  = 0;
  localparam int MP_ALARM_IND_EN   = 1;
  localparam int MP_PATTERN_CLK    = 4;
  // low group: live status, edge select, mask and flag share positions
  localparam int LO_SIGNAL_LOSS    = 0;
  localparam int LO_ALARM_IND      = 1;
  localparam int LO_DRIVER_FAULT   = 2;
  localparam int LO_TX_CLOCK_LOST  = 3;
  localparam int LO_PATTERN_SYNC   = 4;
  localparam int LO_LOOP_DEACT     = 5;
  localparam int LO_LOOP_ACT       = 6;
  // line_status_high
  localparam int HI_REMOTE_LOOP    = 5;
  // high flag group (pulse events), bit order of the event input vector:
  // 0 counter overflow, 1 second timer, 2 code violation, 3 excess zero,
  // 4 pattern error, 5 jitter fifo under, 6 jitter fifo over, 7 waveform gen

  // ----------------------------------------------------------------
  // interrupt pin modes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] INT_PIN_OPEN_DRAIN = 2'h0;
  localparam logic [1:0] INT_PIN_PP_LOW     = 2'h1;
  localparam logic [1:0] INT_PIN_PP_HIGH    = 2'h2;
  localparam logic [7:0] RST_GLOBAL_CONFIG  = 8'h00;
  localparam logic [7:0] RST_MAINT_PATTERN  = 8'h00;
  localparam logic [7:0] RST_MASK_LOW       = 8'h7F;
  localparam logic [7:0] RST_MASK_HIGH      = 8'hFF;
  localparam logic [7:0] RST_EDGE_SEL       = 8'h00;
  localparam logic [7:0] GCF_RW_BITS        = 8'h07;
  localparam logic [7:0] LOW_RW_BITS        = 8'h7F;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 40;
  localparam int TX_CLK_LOSS_REF_CYCLES = 70;
  localparam int REF_STOP_NS            = 2000;
  localparam int REF_STOP_CLKS          = REF_STOP_NS / CLK_PERIOD_NS;

endpackage : lui_pkg
